//--- oovfr_top.sv
// Contract
// - Response 00: hold high side off, low side on while overvoltage persists.
// - Response 01: keep regulating for delay, then act per retry field.
// - Response 10: disable output at once, then follow retry field.
// - Writing response 11 is unsupported and raises a CML fault.
// - Any overvoltage detection sets the overvoltage fault status bit.
// - Overvoltage detection drives ALERT active unless masked.
// - Fault bit stays set until cleared; CLEAR_FAULTS clears it.
// - Channel commanded off then on clears the latched fault bit.
// - Bias power cycle also clears the bit; nothing beyond these three may.
// - Retry field not 111: no restart until fault cleared or channel off.
// - Retry field 111: restart endlessly until off, bias loss, other fault; no other fault stops it here, only off or bias loss.
// - Restart spacing comes from the retry interval setting.
// - Bits 2:0 give the action delay in 10 us steps.
// - Delay field only applies to the deglitched response.
// - Only 0x80, 0xB8, 0x4n, 0x78+n accepted; others ignored with CML fault.
// - Fault sets summary, status word and output status overvoltage bits.
// - Retry wait is longer of interval and output decay below 12.5%.
`timescale 1ns/1ps
module oovfr_top #(
  parameter int CYC_PER_MS = oovfr_pkg::RETRY_UNIT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic cfg_wr_stb,
  input wire logic [7:0] cfg_wr_data,
  output logic [7:0] cfg_rd_data,
  input wire logic clear_faults_stb,
  input wire logic operation_on,
  input wire logic channel_run_control_pin,
  input wire logic ov_detect,
  input wire logic vout_decayed,
  input wire logic alert_mask,
  input wire logic [16:0] retry_interval_setting,
  output logic high_side_en,
  output logic low_side_on,
  output logic status_byte_vout_ov,
  output logic status_word_vout,
  output logic status_vout_ov_fault,
  output logic alert_b,
  output logic cml_fault
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic code_ok(input logic [7:0] d);
    code_ok = (d == oovfr_pkg::CODE_LATCH) || (d == oovfr_pkg::CODE_RETRY)
      || ((d & oovfr_pkg::CODE_N_MASK) == oovfr_pkg::CODE_DEGL_LATCH)
      || ((d & oovfr_pkg::CODE_N_MASK) == oovfr_pkg::CODE_DEGL_RETRY);
  endfunction

  // Three-stage filter: the output moves only when stages two and three agree
  function automatic logic filt(input logic s2, input logic s3, input logic cur);
    filt = (s2 == s3) ? s3 : cur;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] run_sh_r;
  logic [2:0] ov_sh_r;
  logic run_f_r;
  logic ov_f_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_sh_r <= 3'h0;
      ov_sh_r <= 3'h0;
      run_f_r <= 1'b0;
      ov_f_r <= 1'b0;
    end else begin
      run_sh_r <= {run_sh_r[1:0], channel_run_control_pin};
      ov_sh_r <= {ov_sh_r[1:0], ov_detect};
      run_f_r <= filt(run_sh_r[1], run_sh_r[2], run_f_r);
      ov_f_r <= filt(ov_sh_r[1], ov_sh_r[2], ov_f_r);
    end
  end

  // ----------------------------------------------------------------
  // Configuration byte
  // ----------------------------------------------------------------
  logic [7:0] cfg_r;
  logic cml_r;
  wire wr_ok = cfg_wr_stb && code_ok(cfg_wr_data);
  wire wr_bad = cfg_wr_stb && !code_ok(cfg_wr_data);
  wire [1:0] resp = cfg_r[oovfr_pkg::RESP_HI:oovfr_pkg::RESP_LO];
  wire [2:0] retry = cfg_r[oovfr_pkg::RETRY_HI:oovfr_pkg::RETRY_LO];
  wire [2:0] dly_n = cfg_r[oovfr_pkg::DLY_HI:oovfr_pkg::DLY_LO];
  wire [oovfr_pkg::DLY_CNT_W-1:0] dly_cyc =
    oovfr_pkg::DLY_CNT_W'(dly_n * oovfr_pkg::DLY_STEP_CYC);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= oovfr_pkg::CFG_RESET;
      cml_r <= 1'b0;
    end else begin
      if (wr_ok) begin
        cfg_r <= cfg_wr_data;
      end
      // Set wins over a clear in the same cycle
      cml_r <= wr_bad || (cml_r && !clear_faults_stb);
    end
  end

  // ----------------------------------------------------------------
  // Channel run state and fault status
  // ----------------------------------------------------------------
  logic chan_on_d_r;
  logic fault_r;
  wire chan_on = run_f_r && operation_on;
  wire chan_rise = chan_on && !chan_on_d_r;
  wire fault_clr = clear_faults_stb || chan_rise;
  wire fault_nxt = ov_f_r || (fault_r && !fault_clr);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan_on_d_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      chan_on_d_r <= chan_on;
      fault_r <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Response state machine
  // ----------------------------------------------------------------
  oovfr_pkg::oovfr_state_type st_r;
  oovfr_pkg::oovfr_state_type st_nxt;
  oovfr_pkg::oovfr_state_type shut_st;
  logic [oovfr_pkg::DLY_CNT_W-1:0] deg_cnt_r;
  logic [oovfr_pkg::PRE_CNT_W-1:0] pre_cnt_r;
  logic [oovfr_pkg::MS_CNT_W-1:0] ms_cnt_r;
  wire pre_wrap = (pre_cnt_r == oovfr_pkg::PRE_CNT_W'(CYC_PER_MS - 1));
  wire deg_done = (oovfr_pkg::DLY_CNT_W'(deg_cnt_r + 1'b1) >= dly_cyc);
  // Interval alone is not enough: the rail must also have decayed
  wire retry_done = (ms_cnt_r >= retry_interval_setting) && vout_decayed;

  assign shut_st = (retry == oovfr_pkg::RETRY_ENDLESS) ?
    oovfr_pkg::ST_RETRY_WAIT : oovfr_pkg::ST_LATCHED;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      oovfr_pkg::ST_REGULATE: begin
        if (ov_f_r && resp == oovfr_pkg::RESP_DEGLITCH) begin
          st_nxt = (dly_cyc == '0) ? shut_st : oovfr_pkg::ST_DEGLITCH;
        end else if (ov_f_r && resp == oovfr_pkg::RESP_IMMEDIATE) begin
          st_nxt = shut_st;
        end
      end
      oovfr_pkg::ST_DEGLITCH: begin
        if (!ov_f_r) begin
          st_nxt = oovfr_pkg::ST_REGULATE;
        end else if (deg_done) begin
          st_nxt = shut_st;
        end
      end
      oovfr_pkg::ST_LATCHED: begin
        if (clear_faults_stb) begin
          st_nxt = oovfr_pkg::ST_REGULATE;
        end
      end
      oovfr_pkg::ST_RETRY_WAIT: begin
        if (retry_done) begin
          st_nxt = oovfr_pkg::ST_REGULATE;
        end
      end
      default: begin
        st_nxt = oovfr_pkg::ST_REGULATE;
      end
    endcase
    // Off channel drops any pending or latched action
    if (!chan_on) begin
      st_nxt = oovfr_pkg::ST_REGULATE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= oovfr_pkg::ST_REGULATE;
      deg_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      deg_cnt_r <= (st_r == oovfr_pkg::ST_DEGLITCH) ?
        oovfr_pkg::DLY_CNT_W'(deg_cnt_r + 1'b1) : '0;
    end
  end

  // Millisecond prescaler; the wait starts at the shutdown
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_r <= '0;
      ms_cnt_r <= '0;
    end else if (st_r != oovfr_pkg::ST_RETRY_WAIT) begin
      pre_cnt_r <= '0;
      ms_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_wrap ? '0 : oovfr_pkg::PRE_CNT_W'(pre_cnt_r + 1'b1);
      if (pre_wrap && ms_cnt_r != '1) begin
        ms_cnt_r <= oovfr_pkg::MS_CNT_W'(ms_cnt_r + 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic hs_r;
  logic ls_r;
  logic alert_b_r;
  wire running_nxt = (st_nxt == oovfr_pkg::ST_REGULATE) ||
    (st_nxt == oovfr_pkg::ST_DEGLITCH);
  wire pull_down = ov_f_r && (resp == oovfr_pkg::RESP_PULLDOWN);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hs_r <= 1'b0;
      ls_r <= 1'b0;
      alert_b_r <= 1'b1;
    end else begin
      hs_r <= chan_on && running_nxt && !pull_down;
      ls_r <= chan_on && pull_down;
      alert_b_r <= !(fault_nxt && !alert_mask);
    end
  end

  assign cfg_rd_data = cfg_r;
  assign high_side_en = hs_r;
  assign low_side_on = ls_r;
  assign status_byte_vout_ov = fault_r;
  assign status_word_vout = fault_r;
  assign status_vout_ov_fault = fault_r;
  assign alert_b = alert_b_r;
  assign cml_fault = cml_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_bad_write_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_bad |=> cml_r && cfg_r == $past(cfg_r))
    else $error("rejected write changed config or missed cml flag");
  chk_good_write_stored: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wr_ok |=> cfg_r == $past(cfg_wr_data) && cfg_r[7:6] != 2'h3)
    else $error("accepted write not stored");
  chk_fault_status_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ov_f_r |=> status_byte_vout_ov && status_word_vout && status_vout_ov_fault)
    else $error("overvoltage did not set status bits");
  chk_alert_on_fault: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ov_f_r && !alert_mask |=> !alert_b)
    else $error("alert not asserted on fault");
  chk_clear_faults: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fault_r && clear_faults_stb && !ov_f_r |=> !fault_r)
    else $error("clear faults did not clear bit");
  chk_sticky_fault: assert property (@(posedge clk_sys) disable iff (!rst_b)
    fault_r && !fault_clr |=> fault_r)
    else $error("fault bit cleared without cause");
  chk_immediate_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_r == oovfr_pkg::ST_REGULATE && ov_f_r && resp == oovfr_pkg::RESP_IMMEDIATE
    |=> !high_side_en && st_r != oovfr_pkg::ST_DEGLITCH)
    else $error("immediate response did not disable output");
  chk_latch_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_r == oovfr_pkg::ST_LATCHED && chan_on && !clear_faults_stb
    |=> st_r == oovfr_pkg::ST_LATCHED && !high_side_en)
    else $error("latched shutdown restarted");
  chk_retry_spacing: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_r == oovfr_pkg::ST_RETRY_WAIT && chan_on && ms_cnt_r < retry_interval_setting
    |=> st_r == oovfr_pkg::ST_RETRY_WAIT)
    else $error("restart before retry interval");
  chk_deglitch_abandon: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_r == oovfr_pkg::ST_DEGLITCH && !ov_f_r |=> st_r == oovfr_pkg::ST_REGULATE)
    else $error("deglitch not abandoned");
  chk_pulldown_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
    chan_on && pull_down |=> low_side_on && !high_side_en ##1 st_r == oovfr_pkg::ST_REGULATE)
    else $error("pull down response wrong");

endmodule

//--- oovfr_pkg.sv
package oovfr_pkg;

  // ----------------------------------------------------------------
  // Configuration byte layout
  // ----------------------------------------------------------------
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DLY_HI = 2;
  localparam int DLY_LO = 0;
  localparam logic [7:0] CFG_RESET = 8'hB8;

  // Response field codes
  localparam logic [1:0] RESP_PULLDOWN = 2'h0;
  localparam logic [1:0] RESP_DEGLITCH = 2'h1;
  localparam logic [1:0] RESP_IMMEDIATE = 2'h2;
  // Retry field code for endless restart
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;

  // Accepted codes
  localparam logic [7:0] CODE_LATCH = 8'h80;
  localparam logic [7:0] CODE_RETRY = 8'hB8;
  localparam logic [7:0] CODE_DEGL_LATCH = 8'h40;
  localparam logic [7:0] CODE_DEGL_RETRY = 8'h78;
  localparam logic [7:0] CODE_N_MASK = 8'hF8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int DLY_STEP_PS = 10000000;
  localparam int DLY_STEP_CYC = DLY_STEP_PS / CLK_PERIOD_PS;
  localparam int RETRY_UNIT_PS = 1000000000;
  localparam int RETRY_UNIT_CYC = RETRY_UNIT_PS / CLK_PERIOD_PS;
  localparam int DLY_CNT_W = 12;
  localparam int MS_CNT_W = 17;
  localparam int PRE_CNT_W = 16;

  // ----------------------------------------------------------------
  // Fault response states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_REGULATE = 4'b0001,
    ST_DEGLITCH = 4'b0010,
    ST_LATCHED = 4'b0100,
    ST_RETRY_WAIT = 4'b1000
  } oovfr_state_type;

endpackage

//--- oovfr_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host side of the command interface
// ----------------------------------------------------------------
module oovfr_host (
  input wire logic clk_sys,
  output logic cfg_wr_stb,
  output logic [7:0] cfg_wr_data,
  output logic clear_faults_stb,
  output logic [16:0] retry_interval_setting
);
  initial begin
    cfg_wr_stb = 1'b0;
    cfg_wr_data = 8'h00;
    clear_faults_stb = 1'b0;
    // Shortest legal interval keeps the retry runs brief
    retry_interval_setting = 17'h0_0078;
  end

  task automatic write_cfg(input logic [7:0] value);
    @(negedge clk_sys);
    cfg_wr_stb = 1'b1;
    cfg_wr_data = value;
    @(negedge clk_sys);
    cfg_wr_stb = 1'b0;
    // Data is no longer qualified, so show a changed pattern
    cfg_wr_data = ~value;
  endtask

  task automatic clear_faults();
    @(negedge clk_sys);
    clear_faults_stb = 1'b1;
    @(negedge clk_sys);
    clear_faults_stb = 1'b0;
  endtask
endmodule

//--- test_oovfr_top.sv
`timescale 1ns/1ps
module test_oovfr_top;
  logic clk_sys, rst_b, operation_on, channel_run_control_pin, ov_detect;
  logic vout_decayed, alert_mask, cfg_wr_stb, clear_faults_stb;
  logic high_side_en, low_side_on, alert_b, cml_fault, st_byte, st_word, st_vout;
  logic [7:0] cfg_wr_data, cfg_rd_data, last_good;
  logic [16:0] retry_interval_setting;
  int miscompares = 0;
  int compares = 0;
  int n;
  typedef struct packed { logic [7:0] data; logic good; } oovfr_row_type;
  oovfr_row_type rows [0:9] = '{'{8'h80, 1'b1}, '{8'hB8, 1'b1}, '{8'h40, 1'b1},
    '{8'h47, 1'b1}, '{8'h78, 1'b1}, '{8'h7F, 1'b1}, '{8'hC0, 1'b0}, '{8'h00, 1'b0},
    '{8'h48, 1'b0}, '{8'hF8, 1'b0}};

  oovfr_host host_u (.clk_sys(clk_sys), .cfg_wr_stb(cfg_wr_stb), .cfg_wr_data(cfg_wr_data),
    .clear_faults_stb(clear_faults_stb), .retry_interval_setting(retry_interval_setting));
  oovfr_top #(.CYC_PER_MS(10)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .cfg_wr_stb(cfg_wr_stb), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
    .clear_faults_stb(clear_faults_stb), .operation_on(operation_on),
    .channel_run_control_pin(channel_run_control_pin), .ov_detect(ov_detect),
    .vout_decayed(vout_decayed), .alert_mask(alert_mask),
    .retry_interval_setting(retry_interval_setting), .high_side_en(high_side_en),
    .low_side_on(low_side_on), .status_byte_vout_ov(st_byte), .status_word_vout(st_word),
    .status_vout_ov_fault(st_vout), .alert_b(alert_b), .cml_fault(cml_fault));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  // Counts falling edges until the high side reaches a level; bound exhausted ends the run
  task automatic wait_hs(input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (high_side_en !== lvl && cnt < bound) begin
      @(negedge clk_sys);
      cnt++;
    end
    if (high_side_en !== lvl) begin
      miscompares++;
      finish_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    operation_on = 1'b1;
    channel_run_control_pin = 1'b1;
    ov_detect = 1'b0;
    vout_decayed = 1'b1;
    alert_mask = 1'b0;
    cycles(8);
    check8(cfg_rd_data, 8'hB8);
    check1(alert_b, 1'b1);
    check1(cml_fault | high_side_en | low_side_on, 1'b0);
    check1(st_vout, 1'b0);
    rst_b = 1'b1;
    cycles(10);
    check1(high_side_en, 1'b1);
    last_good = 8'hB8;
    foreach (rows[i]) begin
      host_u.write_cfg(rows[i].data);
      cycles(1);
      if (rows[i].good) begin
        last_good = rows[i].data;
      end
      check8(cfg_rd_data, last_good);
      check1(cml_fault, ~rows[i].good);
      host_u.clear_faults();
    end
    host_u.write_cfg(8'h80);
    ov_detect = 1'b1;
    wait_hs(1'b0, 20, n);
    check1(n <= 7, 1'b1);
    cycles(2);
    check1(st_byte & st_word & st_vout, 1'b1);
    check1(alert_b, 1'b0);
    ov_detect = 1'b0;
    cycles(100);
    check1(high_side_en | low_side_on, 1'b0);
    check1(st_vout, 1'b1);
    host_u.clear_faults();
    cycles(2);
    check1(st_vout, 1'b0);
    check1(alert_b & high_side_en, 1'b1);
    alert_mask = 1'b1;
    ov_detect = 1'b1;
    cycles(10);
    check1(st_vout, 1'b1);
    check1(alert_b, 1'b1);
    ov_detect = 1'b0;
    cycles(6);
    host_u.clear_faults();
    alert_mask = 1'b0;
    host_u.write_cfg(8'h42);
    ov_detect = 1'b1;
    cycles(600);
    ov_detect = 1'b0;
    cycles(10);
    check1(high_side_en, 1'b1);
    check1(st_vout, 1'b1);
    host_u.clear_faults();
    ov_detect = 1'b1;
    wait_hs(1'b0, 2000, n);
    // Two steps of 400 cycles plus the input filter; a count not restarted fires near 200
    check1(n >= 800 && n <= 812, 1'b1);
    ov_detect = 1'b0;
    cycles(100);
    check1(high_side_en, 1'b0);
    channel_run_control_pin = 1'b0;
    cycles(20);
    channel_run_control_pin = 1'b1;
    cycles(20);
    check1(st_vout, 1'b0);
    check1(high_side_en, 1'b1);
    host_u.write_cfg(8'hB8);
    vout_decayed = 1'b0;
    ov_detect = 1'b1;
    wait_hs(1'b0, 20, n);
    ov_detect = 1'b0;
    cycles(1500);
    check1(high_side_en, 1'b0);
    vout_decayed = 1'b1;
    wait_hs(1'b1, 5, n);
    ov_detect = 1'b1;
    wait_hs(1'b0, 20, n);
    ov_detect = 1'b0;
    wait_hs(1'b1, 1400, n);
    check1(n >= 1190 && n <= 1205, 1'b1);
    check1(st_vout, 1'b1);
    operation_on = 1'b0;
    cycles(3);
    operation_on = 1'b1;
    cycles(3);
    check1(st_vout, 1'b0);
    ov_detect = 1'b1;
    cycles(10);
    ov_detect = 1'b0;
    rst_b = 1'b0;
    cycles(2);
    check1(st_vout, 1'b0);
    check8(cfg_rd_data, 8'hB8);
    rst_b = 1'b1;
    cycles(10);
    check1(high_side_en & alert_b, 1'b1);
    check1(low_side_on | cml_fault | st_vout, 1'b0);
    finish_test();
  end
endmodule
